// *** tid_dispatch.sv ***
// trap and interrupt dispatch unit with mode and bank protection
`timescale 1ns/1ns
`default_nettype none
module tid_dispatch
   import tid_pkg::*;
(
   input  wire logic               core_clk_in,     // core clock
   input  wire logic               rst_in,          // sync reset, high
   input  wire logic               base_we_in,      // write table base register
   input  wire logic [TID_DW-1:0]  base_wdata_in,   // new table base
   input  wire logic               mode_we_in,      // write mode (supervisor only)
   input  wire logic               mode_wdata_in,   // 1 = supervisor
   input  wire logic               trace_we_in,     // write trace enable
   input  wire logic               trace_wdata_in,  // trace enable value
   input  wire logic               bank_we_in,      // write bank protect mask
   input  wire logic [TID_BANKS-1:0] bank_wdata_in, // protect mask
   input  wire logic               irq_in,          // interrupt request, core domain
   input  wire logic [TID_VW-1:0]  irq_vec_in,      // interrupt number
   input  wire logic               instr_done_in,   // instruction retired
   input  wire logic               instr_fp_in,     // decoded floating-point op
   input  wire logic               instr_halt_in,   // stop-execution op
   input  wire logic               instr_swtrap_in, // software trap op
   input  wire logic [TID_VW-1:0]  swtrap_vec_in,   // software trap number
   input  wire logic               instr_multi_in,  // load, store or trap return
   input  wire logic               instr_iret_in,   // trap return
   input  wire logic               prot_acc_in,     // access to protected resource
   input  wire logic               rf_acc_in,       // register file access
   input  wire logic [TID_BANK_W-1:0] rf_bank_in,   // bank accessed
   output logic                    mem_req_out,     // vector fetch request
   output logic [TID_DW-1:0]       mem_addr_out,    // vector fetch address
   input  wire logic               mem_ack_in,      // vector fetch data valid
   input  wire logic [TID_DW-1:0]  mem_rdata_in,    // vector fetch data
   output logic                    stall_out,       // hold pipeline
   output logic                    redirect_out,    // jump to handler pulse
   output logic [TID_DW-1:0]       handler_out,     // handler address
   output logic                    supervisor_out,  // current mode
   output logic                    access_deny_out, // protected access blocked
   output logic                    halted_out,      // stopped by halt
   output logic                    single_cyc_out   // instruction may finish in one cycle
);
   tid_fetch_if fi ();

   logic [TID_DW-1:0]    base_reg;
   logic                 sup_reg;
   logic                 trace_reg;
   logic [TID_BANKS-1:0] bank_reg;
   logic                 halt_reg;
   logic                 pend_reg;
   logic [TID_VW-1:0]    pvec_reg;
   logic                 sup_save_reg;
   logic                 start_reg;
   logic [TID_VW-1:0]    svec_reg;
   logic                 redir_reg;
   logic [TID_DW-1:0]    hdl_reg;

   // lookup of a bank against the protect mask
   function automatic logic bank_guarded(input logic [TID_BANKS-1:0] mask,
                                         input logic [TID_BANK_W-1:0] bank);
      bank_guarded = mask[bank];
   endfunction

   wire logic user_mode  = !sup_reg;
   wire logic deny_prot  = user_mode && prot_acc_in;
   wire logic deny_bank  = user_mode && rf_acc_in
                           && bank_guarded(bank_reg, rf_bank_in);
   wire logic deny_any   = deny_prot || deny_bank;
   wire logic trace_hit  = trace_reg && instr_done_in;
   wire logic fp_hit     = instr_fp_in;
   wire logic sw_hit     = instr_swtrap_in;

   // fixed priority: protection, fp, software trap, interrupt, trace
   wire logic            trap_any = deny_any || fp_hit || sw_hit
                                    || irq_in || trace_hit;
   wire logic [TID_VW-1:0] trap_vec =
      deny_any  ? TID_VEC_PROT :
      fp_hit    ? TID_VEC_FPEMU :
      sw_hit    ? swtrap_vec_in :
      irq_in    ? irq_vec_in : TID_VEC_TRACE;
   wire logic can_start = !fi.busy && !start_reg && !pend_reg;
   wire logic mode_ok   = sup_reg;          // only supervisor changes protected state

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         base_reg  <= TID_BASE_RST;
         sup_reg   <= 1'b1;
         trace_reg <= 1'b0;
         bank_reg  <= '0;
      end else begin
         if (base_we_in && mode_ok) base_reg <= base_wdata_in;
         if (trace_we_in && mode_ok) trace_reg <= trace_wdata_in;
         if (bank_we_in && mode_ok) bank_reg <= bank_wdata_in;
         // traps enter supervisor; return restores the mode saved at entry
         if (start_reg) sup_reg <= 1'b1;
         else if (instr_iret_in) sup_reg <= sup_save_reg;
         else if (mode_we_in && mode_ok) sup_reg <= mode_wdata_in;
      end
   end

   // pending trap latch: only number and mode are kept, never written out
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pend_reg     <= 1'b0;
         pvec_reg     <= '0;
         sup_save_reg <= 1'b1;
      end else begin
         if (trap_any && can_start) begin
            pend_reg     <= 1'b1;
            pvec_reg     <= trap_vec;
            sup_save_reg <= sup_reg;
         end else if (start_reg) begin
            pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         start_reg <= 1'b0;
         svec_reg  <= '0;
      end else begin
         start_reg <= pend_reg && !start_reg && !fi.busy;
         if (pend_reg) svec_reg <= pvec_reg;
      end
   end

   // halt holds until a trap is taken, which is how a debugger resumes
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         halt_reg <= 1'b0;
      end else if (instr_halt_in) begin
         // set wins over a trap start in the same cycle, so no halt is lost
         halt_reg <= 1'b1;
      end else if (start_reg) begin
         halt_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         redir_reg <= 1'b0;
         hdl_reg   <= '0;
      end else begin
         redir_reg <= fi.done;
         if (fi.done) hdl_reg <= fi.handler;
      end
   end

   assign fi.start = start_reg;
   assign fi.vec   = svec_reg;
   assign fi.base  = base_reg;

   tid_fetch_seq u_seq (
      .core_clk_in  (core_clk_in),
      .rst_in       (rst_in),
      .fi           (fi),
      .mem_req_out  (mem_req_out),
      .mem_addr_out (mem_addr_out),
      .mem_ack_in   (mem_ack_in),
      .mem_rdata_in (mem_rdata_in)
   );

   assign stall_out       = pend_reg || start_reg || fi.busy || halt_reg;
   assign redirect_out    = redir_reg;
   assign handler_out     = hdl_reg;
   assign supervisor_out  = sup_reg;
   assign access_deny_out = deny_any;
   assign halted_out      = halt_reg;
   assign single_cyc_out  = !instr_multi_in && !instr_iret_in;
endmodule
`default_nettype wire

// *** tid_dispatch_properties.sv ***
// port-level checker for the trap and interrupt dispatch unit
`timescale 1ns/1ns
`default_nettype none
module tid_dispatch_properties
   import tid_pkg::*;
(
   input wire logic              core_clk_in,     // clock
   input wire logic              rst_in,          // reset
   input wire logic              instr_fp_in,     // fp op
   input wire logic              instr_multi_in,  // multi-cycle op
   input wire logic              instr_iret_in,   // trap return
   input wire logic              prot_acc_in,     // protected access
   input wire logic              mem_ack_in,      // fetch ack
   input wire logic [TID_DW-1:0] mem_rdata_in,    // fetch data
   input wire logic              mem_req_out,     // fetch request
   input wire logic [TID_DW-1:0] mem_addr_out,    // fetch address
   input wire logic              stall_out,       // stall
   input wire logic              redirect_out,    // redirect pulse
   input wire logic [TID_DW-1:0] handler_out,     // handler
   input wire logic              supervisor_out,  // mode
   input wire logic              access_deny_out, // deny
   input wire logic              halted_out,      // halted
   input wire logic              single_cyc_out   // single cycle
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   a_req_holds: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
      else $error("fetch request or address moved before ack");
   a_fetch_delay: assert property ($rose(stall_out) && !halted_out |-> ##5 $rose(mem_req_out))
      else $error("vector fetch not issued after overhead cycles");
   a_handler_load: assert property (mem_req_out && mem_ack_in && $past(mem_req_out)
      |-> ##2 redirect_out && handler_out == $past(mem_rdata_in, 2))
      else $error("handler not taken from fetched word");
   a_redirect_pulse: assert property (redirect_out |=> !redirect_out)
      else $error("redirect longer than one cycle");
   a_user_denied: assert property (prot_acc_in && !supervisor_out |-> access_deny_out)
      else $error("user access to protected resource allowed");
   a_super_allowed: assert property (supervisor_out |-> !access_deny_out)
      else $error("supervisor access denied");
   a_entry_super: assert property (redirect_out |-> supervisor_out)
      else $error("handler entered outside supervisor mode");
   a_one_cycle: assert property (single_cyc_out == !(instr_multi_in || instr_iret_in))
      else $error("single cycle flag wrong");
   a_no_save: assert property (mem_req_out |-> stall_out && !redirect_out)
      else $error("memory access outside vector fetch");
   a_fp_trap: assert property (instr_fp_in && !stall_out |=> stall_out)
      else $error("fp op did not trap");
endmodule
bind tid_dispatch tid_dispatch_properties i_props (.core_clk_in(core_clk_in), .rst_in(rst_in),
   .instr_fp_in(instr_fp_in), .instr_multi_in(instr_multi_in), .instr_iret_in(instr_iret_in),
   .prot_acc_in(prot_acc_in), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
   .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out), .stall_out(stall_out),
   .redirect_out(redirect_out), .handler_out(handler_out), .supervisor_out(supervisor_out),
   .access_deny_out(access_deny_out), .halted_out(halted_out), .single_cyc_out(single_cyc_out));
`default_nettype wire

// *** tid_fetch_if.sv ***
// vector fetch carrier between dispatch core and fetch sequencer
`timescale 1ns/1ns
`default_nettype none
interface tid_fetch_if;
   import tid_pkg::*;
   logic              start;
   logic [TID_VW-1:0] vec;
   logic [TID_DW-1:0] base;
   logic              done;
   logic [TID_DW-1:0] handler;
   logic              busy;
   modport core (output start, vec, base, input done, handler, busy);
   modport seq  (input start, vec, base, output done, handler, busy);
endinterface
`default_nettype wire

// *** tid_fetch_seq.sv ***
// vector fetch sequencer: overhead cycles then one memory read
`timescale 1ns/1ns
`default_nettype none
module tid_fetch_seq
   import tid_pkg::*;
(
   input  wire logic        core_clk_in,   // core clock
   input  wire logic        rst_in,        // sync reset, high
   tid_fetch_if.seq         fi,            // fetch request side
   output logic             mem_req_out,   // read request
   output logic [TID_DW-1:0] mem_addr_out, // read address
   input  wire logic        mem_ack_in,    // read data valid
   input  wire logic [TID_DW-1:0] mem_rdata_in // read data
);
   tid_state_t        state_reg, state_next;
   logic [1:0]        ovh_reg;
   logic [TID_DW-1:0] addr_reg;
   logic [TID_DW-1:0] hdl_reg;
   logic              done_reg;

   wire logic [TID_DW-1:0] entry_addr =
      fi.base + {{(TID_DW-TID_VW-TID_ENTRY_SHIFT){1'b0}}, fi.vec, 2'h0};

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         TID_IDLE: if (fi.start) state_next = TID_OVH;
         TID_OVH:  if (ovh_reg == TID_OVH_LAST) state_next = TID_REQ;
         TID_REQ:  state_next = TID_WAIT;
         TID_WAIT: if (mem_ack_in) state_next = TID_GO;
         TID_GO:   state_next = TID_IDLE;
         default:  state_next = TID_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_reg <= TID_IDLE;
         ovh_reg   <= 2'h0;
         addr_reg  <= '0;
         hdl_reg   <= '0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         ovh_reg   <= (state_reg == TID_OVH) ? ovh_reg + 2'h1 : 2'h0;
         if (state_reg == TID_IDLE && fi.start) addr_reg <= entry_addr;
         if (state_reg == TID_WAIT && mem_ack_in) hdl_reg <= mem_rdata_in;
         done_reg  <= (state_reg == TID_WAIT) && mem_ack_in;
      end
   end

   assign mem_req_out  = (state_reg == TID_REQ) || (state_reg == TID_WAIT);
   assign mem_addr_out = addr_reg;
   assign fi.done      = done_reg;
   assign fi.handler   = hdl_reg;
   assign fi.busy      = (state_reg != TID_IDLE);
endmodule
`default_nettype wire

// *** tid_mem_model.sv ***
// memory model answering vector fetches after a set latency
`timescale 1ns/1ns
`default_nettype none
module tid_mem_model
   import tid_pkg::*;
(
   input  wire logic              core_clk_in,  // clock
   input  wire logic              rst_in,       // reset
   input  wire logic              mem_req_in,   // fetch request
   input  wire logic [TID_DW-1:0] mem_addr_in,  // fetch address
   input  wire logic [3:0]        lat_in,       // wait cycles, at least 1
   output logic                   mem_ack_out,  // data valid pulse
   output logic [TID_DW-1:0]      mem_rdata_out // read data
);
   logic [3:0] cnt_reg;
   // idle data flips every cycle so stale values never look valid
   always_ff @(posedge core_clk_in) begin
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      cnt_reg       <= 4'h0;
      if (rst_in)
         mem_rdata_out <= 32'h0000_0000;
      else if (mem_req_in && !mem_ack_out) begin
         cnt_reg <= cnt_reg + 4'h1;
         if (cnt_reg + 4'h1 == lat_in) begin
            mem_ack_out   <= 1'b1;
            mem_rdata_out <= {mem_addr_in[15:0], ~mem_addr_in[15:0]};
         end
      end
   end
endmodule
`default_nettype wire

// *** tid_pkg.sv ***
// shared constants and types for the trap and interrupt dispatch unit
package tid_pkg;
   localparam int          TID_DW          = 32;
   localparam int          TID_VEC_N       = 256;               // table entries
   localparam int          TID_VW          = 8;                 // vector number width
   localparam int          TID_TABLE_BYTES = 1024;              // whole table
   localparam int          TID_ENTRY_BYTES = TID_TABLE_BYTES / TID_VEC_N;
   localparam int          TID_ENTRY_SHIFT = 2;                 // log2 of entry bytes
   localparam int          TID_EXTRA_CYC   = 3;                 // overhead beyond memory access
   localparam int          TID_BANKS       = 16;                // register file banks
   localparam int          TID_BANK_W      = 4;
   localparam logic [1:0]  TID_OVH_LAST    = 2'h2;              // overhead counter end value
   // trap numbers of this unit; TID_VEC_HALT is defined but not used
   localparam logic [7:0]  TID_VEC_TRACE   = 8'h0F;
   localparam logic [7:0]  TID_VEC_PROT    = 8'h05;
   localparam logic [7:0]  TID_VEC_FPEMU   = 8'h20;
   localparam logic [7:0]  TID_VEC_HALT    = 8'h0E;
   localparam logic [TID_DW-1:0] TID_BASE_RST = 32'h0000_0000;

   typedef enum logic [4:0] {
      TID_IDLE  = 5'h01,
      TID_OVH   = 5'h02,
      TID_REQ   = 5'h04,
      TID_WAIT  = 5'h08,
      TID_GO    = 5'h10
   } tid_state_t;
endpackage

// *** trap_interrupt_dispatch_tb_top.sv ***
// self-checking bench for the trap and interrupt dispatch unit
`timescale 1ns/1ns
`default_nettype none
module trap_interrupt_dispatch_tb_top;
   import tid_pkg::*;
   logic                 clk = 1'b0, rst = 1'b1;
   logic                 base_we = 1'b0, mode_we = 1'b0, mode_wd = 1'b0, trace_we = 1'b0;
   logic                 trace_wd = 1'b0, bank_we = 1'b0, irq = 1'b0, done = 1'b0, fp = 1'b0;
   logic                 halt = 1'b0, swt = 1'b0, multi = 1'b0, iret = 1'b0, prot = 1'b0;
   logic                 rf_acc = 1'b0, mem_req, mem_ack, stall, redir, sup, deny, halted, single;
   logic [TID_BANKS-1:0] bank_wd = 16'h0000;
   logic [TID_VW-1:0]    irq_vec = 8'h00, sw_vec = 8'h00, v;
   logic [3:0]           rf_bank = 4'h0, lat = 4'h1;
   logic [TID_DW-1:0]    base_wd = 32'h0, base = 32'h0, mem_addr, mem_rdata, handler;
   int                   err_total = 0, n_tests = 0, cyc = 0, k;
   tid_dispatch i_dut (.core_clk_in(clk), .rst_in(rst), .base_we_in(base_we),
      .base_wdata_in(base_wd), .mode_we_in(mode_we), .mode_wdata_in(mode_wd),
      .trace_we_in(trace_we), .trace_wdata_in(trace_wd), .bank_we_in(bank_we),
      .bank_wdata_in(bank_wd), .irq_in(irq), .irq_vec_in(irq_vec), .instr_done_in(done),
      .instr_fp_in(fp), .instr_halt_in(halt), .instr_swtrap_in(swt), .swtrap_vec_in(sw_vec),
      .instr_multi_in(multi), .instr_iret_in(iret), .prot_acc_in(prot), .rf_acc_in(rf_acc),
      .rf_bank_in(rf_bank), .mem_req_out(mem_req), .mem_addr_out(mem_addr),
      .mem_ack_in(mem_ack), .mem_rdata_in(mem_rdata), .stall_out(stall), .redirect_out(redir),
      .handler_out(handler), .supervisor_out(sup), .access_deny_out(deny),
      .halted_out(halted), .single_cyc_out(single));
   tid_mem_model i_mem (.core_clk_in(clk), .rst_in(rst), .mem_req_in(mem_req),
      .mem_addr_in(mem_addr), .lat_in(lat), .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata));
   initial forever #20 clk = ~clk;
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic check(input string what, input logic [TID_DW-1:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step();
      @(posedge clk) #2;
   endtask
   function automatic logic [TID_DW-1:0] word_at(input logic [TID_DW-1:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction
   // caller raises the trap cause just before this, pulses drop after one edge
   task automatic run_trap(input logic [TID_VW-1:0] vec);
      logic [TID_DW-1:0] exp_addr;
      int i;
      exp_addr = base + {22'h0, vec, 2'h0};
      step();
      {irq, done, fp, halt, swt, prot, rf_acc} = 7'h00;
      for (i = 0; i < 60 && mem_req !== 1'b1; i++) step();
      check("overhead cycles", i, TID_EXTRA_CYC + 2);
      check("fetch address", mem_addr, exp_addr);
      for (i = 0; i < 60 && redir !== 1'b1; i++) step();
      check("fetch cycles", i, lat + 2);
      check("handler", handler, word_at(exp_addr));
      check("mode after entry", {31'h0, sup}, 32'h1);
      step();
   endtask
   initial begin
      void'($urandom(90));
      repeat (16) @(posedge clk);
      #2 rst = 1'b0;
      check("reset mode", {31'h0, sup}, 32'h1);
      {bank_we, bank_wd} = {1'b1, 16'h00F0};
      for (k = 0; k < 12; k++) begin
         {base_we, base_wd} = {1'b1, $urandom};
         base = base_wd;
         lat = 4'($urandom_range(8, 1));
         v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         step();
         {base_we, bank_we} = 2'b00;
         if (k[0]) {swt, sw_vec} = {1'b1, v};
         else {irq, irq_vec} = {1'b1, v};
         run_trap(v);
      end
      {fp, irq, irq_vec} = {2'b11, 8'h33};
      run_trap(TID_VEC_FPEMU);
      {trace_we, trace_wd} = 2'b11;
      step();
      {trace_we, done} = 2'b01;
      run_trap(TID_VEC_TRACE);
      {trace_we, trace_wd, mode_we, mode_wd} = 4'b1010;
      step();
      check("user mode", {31'h0, sup}, 32'h0);
      {trace_we, mode_we, base_we, base_wd} = {3'b001, ~base};
      step();
      {base_we, rf_acc, rf_bank} = {2'b01, 4'h2};
      #1 check("open bank", {31'h0, deny}, 32'h0);
      step();
      rf_bank = 4'h5;
      #1 check("guarded bank", {31'h0, deny}, 32'h1);
      run_trap(TID_VEC_PROT);
      halt = 1'b1;
      step();
      halt = 1'b0;
      step();
      check("halted", {31'h0, halted}, 32'h1);
      check("stall while halted", {31'h0, stall}, 32'h1);
      {irq, irq_vec} = {1'b1, 8'h11};
      run_trap(8'h11);
      check("halt cleared", {31'h0, halted}, 32'h0);
      for (k = 0; k < 3; k++) begin
         {multi, iret} = 2'(k);
         #1 check("single cycle", {31'h0, single}, {31'h0, k == 0});
         step();
      end
      {multi, iret} = 2'b00;
      step();
      print_verdict();
   end
endmodule
`default_nettype wire
